// File: verilog/radio_ctl_pkg.sv
// Shared types and constants for the radio start-up, reset and crystal control.
// Assumes a single 20 MHz crystal-derived clock and same-clock command strobes.
package radio_ctl_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_PERIOD_NS      = 50;
    // Time the core holds ready low after a soft reset while defaults reload
    localparam int unsigned SOFT_SETTLE_NS     = 1000;
    localparam int unsigned SOFT_SETTLE_CYC    =
        (SOFT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W           = 6;
    localparam logic [5:0]  SETTLE_LOAD        = SOFT_SETTLE_CYC[5:0];

    // ========================================================================
    // General output 0 divider
    // ========================================================================
    localparam int unsigned GO0_DIV            = 192;
    localparam int unsigned DIV_W              = 7;
    localparam logic [6:0]  DIV_HALF_LAST      = 7'(GO0_DIV / 2 - 1);
    localparam logic [6:0]  DIV_RESET          = 7'h00;
    localparam logic        GO0_SEL_RESET      = 1'b0;

    // ========================================================================
    // State numbers reported to software
    // ========================================================================
    localparam int unsigned STATE_NUM_W        = 5;
    localparam logic [4:0]  NUM_SLEEP          = 5'h00;
    localparam logic [4:0]  NUM_IDLE           = 5'h01;
    localparam logic [4:0]  NUM_CRYSTAL_OFF_STATE           = 5'h02;
    localparam logic [4:0]  NUM_WAKE           = 5'h03;
    localparam logic [4:0]  NUM_UNDERFLOW      = 5'h16;

    typedef enum logic [6:0] {
        ST_IDLE      = 7'h01,
        ST_CRYSTAL_OFF_STATE_ARM  = 7'h02,
        ST_SLEEP_ARM = 7'h04,
        ST_CRYSTAL_OFF_STATE      = 7'h08,
        ST_SLEEP     = 7'h10,
        ST_WAKE      = 7'h20,
        ST_UNDERFLOW = 7'h40
    } ctl_state_t;

    // Command strobes from the serial port decoder
    typedef struct packed {
        logic soft_reset;
        logic crystal_off;
        logic power_down;
        logic go_idle;
    } strobe_t;

    // Static configuration held by the host-facing register logic
    typedef struct packed {
        logic xosc_force_on;
        logic go0_sel_we;
        logic go0_sel;
    } ctl_cfg_t;

endpackage

// File: verilog/radio_reset_ctl.sv
// Start-up, reset, crystal gating and core regulator control of the radio.
// Assumes strobes come from the serial decoder on CLK_I; chip select and the
// oscillator-stable flag are asynchronous and are synchronised here.
//
// Contract
// R1: State changes come from host strobes or internal events like a transmit underflow.
// R2: The current state is reported as a number on the state number status output.
// R3: After any reset general output 0 carries the crystal clock divided by 192.
// R4: The host should reselect general output 0 after reset to stop the divided clock.
// R5: Chip ready low goes low when power-up is done and shows on serial out with chip select low.
// R6: After reset the controller sits in IDLE with the crystal oscillator running.
// R7: With chip select low before the oscillator is stable, serial out shows high then low.
// R8: The soft reset strobe restores all defaults and puts the controller in IDLE.
// R9: For manual power-up the host toggles chip select, waits, then sends a soft reset.
// R10: After first power-up the host needs only the soft reset strobe to reset.
// R11: The oscillator is gated automatically unless force-on is set, even in SLEEP.
// R12: In automatic mode crystal-off leads to CRYSTAL_OFF_STATE and power-down to SLEEP, only from IDLE.
// R13: After such a strobe the oscillator stops on chip select high and restarts on low.
// R14: After restart the host waits for serial out low before using the port.
// R15: SLEEP disables the core regulator once chip select goes high after power-down.
// R16: Chip select low in SLEEP re-enables regulator and oscillator and returns to IDLE.
// R17: Crystal-off and power-down strobes outside IDLE are ignored.
`timescale 1ns/1ps

module radio_reset_ctl
    import radio_ctl_pkg::*;
(
    input  wire logic                   CLK_I,
    input  wire logic                   RESET_I,
    input  wire logic                   CSN_I,
    input  wire logic                   XOSC_STABLE_I,
    input  wire strobe_t                STROBE_I,
    input  wire logic                   TX_UNDERFLOW_I,
    input  wire ctl_cfg_t               CFG_I,
    output logic                        SO_O,
    output logic                        SO_OE_O,
    output logic                        XOSC_EN_O,
    output logic                        REG_EN_O,
    output logic                        GO0_O,
    output logic [STATE_NUM_W-1:0]      STATE_NUM_O
);

    // ========================================================================
    // State record
    // ========================================================================
    typedef struct packed {
        ctl_state_t             state;
        logic [STATE_NUM_W-1:0] state_num;
        logic [DIV_W-1:0]       div_cnt;
        logic                   div_clk;
        logic                   go0_sel;
        logic                   go0;
        logic [SETTLE_W-1:0]    settle;
        logic                   xosc_en;
        logic                   reg_en;
        logic                   cs_meta;
        logic                   cs_sync;
        logic                   stable_meta;
        logic                   stable_sync;
    } core_t;

    localparam core_t CORE_RESET = '{
        state:       ST_IDLE,
        state_num:   NUM_IDLE,
        div_cnt:     DIV_RESET,
        div_clk:     1'b0,
        go0_sel:     GO0_SEL_RESET,
        go0:         1'b0,
        settle:      SETTLE_LOAD,
        xosc_en:     1'b1,
        reg_en:      1'b1,
        cs_meta:     1'b1,
        cs_sync:     1'b1,
        stable_meta: 1'b0,
        stable_sync: 1'b0
    };

    core_t r;
    core_t r_nxt;

    logic  ready;

    function automatic logic [STATE_NUM_W-1:0] num_of(input ctl_state_t s);
        logic [STATE_NUM_W-1:0] n;
        n = NUM_IDLE;
        unique case (s)
            ST_SLEEP:     n = NUM_SLEEP;
            ST_CRYSTAL_OFF_STATE:      n = NUM_CRYSTAL_OFF_STATE;
            ST_WAKE:      n = NUM_WAKE;
            ST_UNDERFLOW: n = NUM_UNDERFLOW;
            default:      n = NUM_IDLE;
        endcase
        return n;
    endfunction

    // Core is ready once the oscillator is stable, soft reset has settled and the state is not WAKE, CRYSTAL_OFF_STATE or SLEEP
    assign ready = r.stable_sync && (r.settle == '0) && (r.state != ST_WAKE)
                   && (r.state != ST_CRYSTAL_OFF_STATE) && (r.state != ST_SLEEP);

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        r_nxt = r;
        r_nxt.cs_meta     = CSN_I;
        r_nxt.cs_sync     = r.cs_meta;
        r_nxt.stable_meta = XOSC_STABLE_I;
        r_nxt.stable_sync = r.stable_meta;

        if (r.settle != '0) begin
            r_nxt.settle = r.settle - 1'b1;
        end

        // Free-running divide by 192 for general output 0  [R3]
        if (r.div_cnt == DIV_HALF_LAST) begin
            r_nxt.div_cnt = '0;
            r_nxt.div_clk = ~r.div_clk;
        end else begin
            r_nxt.div_cnt = r.div_cnt + 1'b1;
        end
        if (CFG_I.go0_sel_we) begin
            r_nxt.go0_sel = CFG_I.go0_sel;
        end

        unique case (r.state)
            ST_IDLE: begin
                // Crystal-off and power-down strobes are honoured only here  [R12] [R17]
                if (STROBE_I.power_down) begin
                    r_nxt.state = ST_SLEEP_ARM;
                end else if (STROBE_I.crystal_off && !CFG_I.xosc_force_on) begin
                    r_nxt.state = ST_CRYSTAL_OFF_STATE_ARM;
                end else if (TX_UNDERFLOW_I) begin
                    r_nxt.state = ST_UNDERFLOW;                      // [R1]
                end
            end
            ST_CRYSTAL_OFF_STATE_ARM: begin
                if (r.cs_sync) begin
                    r_nxt.state = ST_CRYSTAL_OFF_STATE;                           // [R13]
                end
            end
            ST_SLEEP_ARM: begin
                if (r.cs_sync) begin
                    r_nxt.state = ST_SLEEP;                          // [R15]
                end
            end
            ST_CRYSTAL_OFF_STATE, ST_SLEEP: begin
                if (!r.cs_sync) begin
                    r_nxt.state = ST_WAKE;                           // [R13] [R16]
                end
            end
            ST_WAKE: begin
                if (r.stable_sync) begin
                    r_nxt.state = ST_IDLE;
                end
            end
            ST_UNDERFLOW: begin
                if (STROBE_I.go_idle) begin
                    r_nxt.state = ST_IDLE;                           // [R1]
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase

        // Soft reset outranks everything and reloads every default  [R8]
        if (STROBE_I.soft_reset) begin
            r_nxt.state   = ST_IDLE;
            r_nxt.div_cnt = DIV_RESET;
            r_nxt.div_clk = 1'b0;
            r_nxt.go0_sel = GO0_SEL_RESET;
            r_nxt.settle  = SETTLE_LOAD;
        end

        // Force-on keeps the crystal alive even through SLEEP  [R11]
        r_nxt.xosc_en = CFG_I.xosc_force_on ||
                        !((r_nxt.state == ST_CRYSTAL_OFF_STATE) || (r_nxt.state == ST_SLEEP));
        r_nxt.reg_en    = (r_nxt.state != ST_SLEEP);                 // [R15] [R16]
        r_nxt.state_num = num_of(r_nxt.state);                       // [R2]
        // Select 1 hands the pin over to the inverted ready flag, low once ready
        r_nxt.go0       = r_nxt.go0_sel ? ~ready : r_nxt.div_clk;
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r <= CORE_RESET;                                         // [R6]
        end else begin
            r <= r_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Serial out is only driven while chip select is low; it then shows the
    // not-ready level, so an early select sees high first  [R5] [R7]
    assign SO_OE_O     = ~r.cs_sync;
    assign SO_O        = ~ready;
    assign XOSC_EN_O   = r.xosc_en;
    assign REG_EN_O    = r.reg_en;
    assign GO0_O       = r.go0;
    assign STATE_NUM_O = r.state_num;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence arm_sleep_s;
        r.state == ST_IDLE && STROBE_I.power_down && !STROBE_I.soft_reset;
    endsequence

    sequence cs_release_s;
        r.state == ST_SLEEP_ARM && r.cs_sync && !STROBE_I.soft_reset;
    endsequence

    sleep_entry_a: assert property (arm_sleep_s |=> r.state == ST_SLEEP_ARM ##0 REG_EN_O) // [R15]
        else $error("power-down strobe did not arm sleep");

    regulator_off_a: assert property (cs_release_s |=> !REG_EN_O && r.state == ST_SLEEP) // [R15]
        else $error("regulator still on in sleep");

    crystal_force_a: assert property (CFG_I.xosc_force_on ##1 CFG_I.xosc_force_on |-> XOSC_EN_O) // [R11]
        else $error("forced crystal was switched off");

    crystal_off_state_gating_a: assert property ((r.state == ST_CRYSTAL_OFF_STATE_ARM && r.cs_sync && !STROBE_I.soft_reset
                                     && !CFG_I.xosc_force_on) |=> !XOSC_EN_O) // [R13]
        else $error("crystal not stopped on chip select release");

    strobe_ignore_a: assert property ((r.state == ST_UNDERFLOW && !STROBE_I.go_idle
                                       && !STROBE_I.soft_reset) |=> r.state == ST_UNDERFLOW) // [R17]
        else $error("strobe outside idle changed state");

    sleep_wake_a: assert property ((r.state == ST_SLEEP && !r.cs_sync && !STROBE_I.soft_reset)
                                   |=> r.state == ST_WAKE && REG_EN_O && XOSC_EN_O) // [R16]
        else $error("chip select low did not wake from sleep");

    soft_reset_a: assert property (STROBE_I.soft_reset |=> r.state == ST_IDLE && SO_O
                                   && r.settle == SETTLE_LOAD) // [R8]
        else $error("soft reset did not restore defaults");

    ready_flag_a: assert property ((SO_OE_O && !r.stable_sync) |-> SO_O) // [R7]
        else $error("ready shown before crystal is stable");

    state_report_a: assert property (##1 STATE_NUM_O == num_of(r.state)) // [R2]
        else $error("state number does not match state");

    divider_edge_a: assert property ((r.div_clk != $past(r.div_clk) && !$past(STROBE_I.soft_reset))
                                     |-> $past(r.div_cnt) == DIV_HALF_LAST) // [R3]
        else $error("general output divider toggled off period");

    // ========================================================================
    // Entry and wake-up checks
    // ========================================================================
    // Released reset must find the controller idle with crystal and regulator on
    reset_defaults_a: assert property ($fell(RESET_I) |-> r.state == ST_IDLE // [R6]
                                       && XOSC_EN_O && REG_EN_O)
        else $error("reset did not leave idle with crystal on");

    underflow_entry_a: assert property ((r.state == ST_IDLE && TX_UNDERFLOW_I // [R1]
                                         && STROBE_I == '0) |=> STATE_NUM_O == NUM_UNDERFLOW)
        else $error("transmit underflow not taken from idle");

    crystal_off_state_entry_a: assert property ((r.state == ST_IDLE && STROBE_I.crystal_off // [R12]
                                    && !STROBE_I.power_down && !STROBE_I.soft_reset
                                    && !CFG_I.xosc_force_on) |=> r.state == ST_CRYSTAL_OFF_STATE_ARM)
        else $error("crystal-off strobe did not arm crystal-off");

    // Arm states are reachable only from idle, whatever strobe arrives elsewhere
    arm_from_idle_a: assert property ((r.state != ST_IDLE) |=> // [R17]
                                      !(r.state inside {ST_CRYSTAL_OFF_STATE_ARM, ST_SLEEP_ARM})
                                      || r.state == $past(r.state))
        else $error("crystal-off or sleep armed outside idle");

    sequence wake_request_s;
        (r.state == ST_CRYSTAL_OFF_STATE || r.state == ST_SLEEP) && !r.cs_sync && !STROBE_I.soft_reset;
    endsequence

    sequence crystal_restart_s;
        r.state == ST_WAKE && XOSC_EN_O && REG_EN_O && STATE_NUM_O == NUM_WAKE;
    endsequence

    wake_chain_a: assert property (wake_request_s |=> crystal_restart_s) // [R13] [R16]
        else $error("chip select low did not restart the crystal");

    wake_idle_a: assert property ((r.state == ST_WAKE && r.stable_sync // [R13] [R16]
                                   && !STROBE_I.soft_reset) |=> r.state == ST_IDLE)
        else $error("stable crystal did not return to idle");

    sleep_gate_a: assert property ((r.state == ST_SLEEP_ARM && r.cs_sync // [R11] [R15]
                                    && !STROBE_I.soft_reset)
                                   |=> XOSC_EN_O == $past(CFG_I.xosc_force_on))
        else $error("crystal gating in sleep ignored force-on");

    // Select 0 must put the divider straight onto the pin
    go0_source_a: assert property ((!r.go0_sel && !CFG_I.go0_sel_we) // [R3]
                                   |=> GO0_O == r.div_clk)
        else $error("general output not carrying the divided clock");

    settle_count_a: assert property ((r.settle != '0 && !STROBE_I.soft_reset) // [R8]
                                     |=> r.settle == $past(r.settle) - 1'b1)
        else $error("soft reset settle count did not step");

endmodule

// File: verification/radio_host_model.sv
// Host controller model: chip select, command strobes and configuration.
// Assumes the bench clock; requests change 2 ns after a rising edge.
`timescale 1ns/1ps
module radio_host_model
    import radio_ctl_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic SO_I,
    input  wire logic SO_OE_I,
    output logic      CSN_O,
    output strobe_t   STROBE_O,
    output ctl_cfg_t  CFG_O
);
    logic so_last = 1'b0;
    logic so_line;
    // An undriven line must not look like the last driven level
    assign so_line = SO_OE_I ? SO_I : ~so_last;
    always @(posedge CLK_I) begin
        if (SO_OE_I) so_last <= SO_I;
    end
    initial begin
        CSN_O = 1'b1;
        STROBE_O = '0;
        CFG_O = '0;
    end
    // ====================
    // Request tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #2;
    endtask
    task automatic cs(input logic lvl);
        CSN_O = lvl;
    endtask
    task automatic force_on(input logic v);
        CFG_O.xosc_force_on = v;
    endtask
    task automatic pulse(input logic [3:0] s);
        STROBE_O = s;
        cyc(1);
        STROBE_O = '0;
    endtask
    task automatic wait_ready(output logic ok);
        int i;
        // A released line says nothing: wait until serial out is driven low
        for (i = 0; i < 2000 && !(SO_OE_I === 1'b1 && so_line === 1'b0); i++) cyc(1);
        ok = (SO_OE_I === 1'b1 && so_line === 1'b0);
    endtask
    // Full bring-up; later resets need only the soft reset strobe
    task automatic power_up(output logic ok);
        logic a;
        CSN_O = 1'b0;
        cyc(1);
        CSN_O = 1'b1;
        cyc(800);
        CSN_O = 1'b0;
        wait_ready(a);
        pulse(4'h8);
        wait_ready(ok);
        ok = ok & a;
        CFG_O.go0_sel = 1'b1;
        CFG_O.go0_sel_we = 1'b1;
        cyc(1);
        CFG_O.go0_sel_we = 1'b0;
    endtask
endmodule

// File: verification/radio_reset_ctl_test.sv
// Self-checking bench for the reset and crystal controller.
// Assumes the host model drives the strobes; the bench models the crystal.
`timescale 1ns/1ps
module radio_reset_ctl_test;
    import radio_ctl_pkg::*;
    localparam logic [3:0] SR = 4'h8;
    localparam logic [3:0] XO = 4'h4;
    localparam logic [3:0] PD = 4'h2;
    localparam logic [3:0] GI = 4'h1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic unf = 1'b0;
    logic csn, stab, so, so_oe, xen, ren, go0, ok;
    logic [4:0] num;
    strobe_t strb;
    ctl_cfg_t cfg;
    int bad_count = 0;
    int checked = 0;
    int osc_cnt = 0;
    int i, k, n;
    logic [31:0] seed = 32'h0000002E;
    radio_reset_ctl DUT (
        .CLK_I          (clk),
        .RESET_I        (rst),
        .CSN_I          (csn),
        .XOSC_STABLE_I  (stab),
        .STROBE_I       (strb),
        .TX_UNDERFLOW_I (unf),
        .CFG_I          (cfg),
        .SO_O           (so),
        .SO_OE_O        (so_oe),
        .XOSC_EN_O      (xen),
        .REG_EN_O       (ren),
        .GO0_O          (go0),
        .STATE_NUM_O    (num)
    );
    radio_host_model host (
        .CLK_I          (clk),
        .SO_I           (so),
        .SO_OE_I        (so_oe),
        .CSN_O          (csn),
        .STROBE_O       (strb),
        .CFG_O          (cfg)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    // Crystal takes 40 cycles to settle, longer than the soft settle time
    always @(posedge clk) begin
        if (xen !== 1'b1) osc_cnt <= 0;
        else if (osc_cnt < 40) osc_cnt <= osc_cnt + 1;
    end
    assign stab = (osc_cnt == 40);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // ====================
    // Checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_num(input logic [4:0] e);
        for (i = 0; i < 500 && num !== e; i++) host.cyc(1);
        chk(num, e);
    endtask
    task automatic go0_gap(output int g);
        logic v;
        v = go0;
        for (g = 0; g < 300 && go0 === v; g++) host.cyc(1);
        v = go0;
        for (g = 0; g < 300 && go0 === v; g++) host.cyc(1);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    // ====================
    // Scenarios
    initial begin
        host.cyc(8);
        rst = 1'b0;
        host.cyc(1);
        chk(num, NUM_IDLE);
        chk(xen, 1'b1);
        chk(ren, 1'b1);
        host.cs(1'b0);
        host.cyc(3);
        chk(so_oe, 1'b1);
        chk(so, 1'b1);
        host.power_up(ok);
        chk(ok, 1'b1);
        chk(go0, 1'b0);
        unf = 1'b1;
        host.cyc(1);
        unf = 1'b0;
        wait_num(NUM_UNDERFLOW);
        // Random strobe mixes, force-on, select and underflow while not idle
        repeat (8) begin
            n = int'(xs() & 32'h000000FF);
            host.force_on(n[4]);
            host.cs(n[5]);
            unf = n[6];
            host.pulse({1'b0, n[0], n[1] | !n[0], 1'b0});
            unf = 1'b0;
            host.cyc(n[3:2] + 2);
            chk(num, NUM_UNDERFLOW);
            chk(xen, 1'b1);
            chk(so_oe, !n[5]);
        end
        host.force_on(1'b0);
        host.cs(1'b0);
        host.pulse(GI);
        wait_num(NUM_IDLE);
        unf = 1'b1;
        host.cyc(1);
        unf = 1'b0;
        host.cyc(2);
        host.pulse(SR);
        chk(so, 1'b1);
        wait_num(NUM_IDLE);
        go0_gap(n);
        chk(n, 96);
        for (k = 0; k < 2; k++) begin
            host.pulse(k ? XO : PD);
            host.cs(1'b1);
            wait_num(k ? NUM_CRYSTAL_OFF_STATE : NUM_SLEEP);
            chk(xen, 1'b0);
            chk(ren, k[0]);
            host.cs(1'b0);
            wait_num(NUM_WAKE);
            chk(xen, 1'b1);
            chk(ren, 1'b1);
            host.wait_ready(ok);
            chk(ok, 1'b1);
            chk(num, NUM_IDLE);
            chk(ren, 1'b1);
        end
        host.force_on(1'b1);
        host.pulse(XO);
        host.cs(1'b1);
        host.cyc(10);
        chk(num, NUM_IDLE);
        chk(xen, 1'b1);
        host.cs(1'b0);
        host.cyc(4);
        host.pulse(PD);
        host.cs(1'b1);
        wait_num(NUM_SLEEP);
        chk(xen, 1'b1);
        chk(ren, 1'b0);
        host.cs(1'b0);
        host.wait_ready(ok);
        chk(ok, 1'b1);
        chk(num, NUM_IDLE);
        stop_test();
    end
endmodule
